// >>> core/annp_params.svh
// Contract
// (R01) bit 15 more-pages request, RW, resets 0
// (R02) bit 14 reserved: writes dropped, reads zero
// (R03) bit 13 message page select, RW, resets 1
// (R04) bit 12 comply acknowledge, RW, resets 0
// (R05) bit 11 toggle, RO, inverse of last exchanged
// (R06) bits 10:0 code, RW, resets to null page
// (R07) message select decides code field meaning
// (R08) register contents sent as next page word
// (R09) read-only capability flag reads 1
// (R10) software reloads fields before every next page
`ifndef ANNP_PARAMS_SVH
`define ANNP_PARAMS_SVH

`define ANNP_ADDR_W        8
// register indices; byte address is four times the index
`define ANNP_IDX_TX        8'h07
`define ANNP_IDX_CAP       8'h06
`define ANNP_BIT_MORE      15
`define ANNP_BIT_RESV      14
`define ANNP_BIT_MSG       13
`define ANNP_BIT_ACK       12
`define ANNP_BIT_TOG       11
`define ANNP_BIT_CAP       2
`define ANNP_RST_MORE      1'b0
`define ANNP_RST_MSG       1'b1
`define ANNP_RST_ACK       1'b0
`define ANNP_RST_TOG       1'b0
`define ANNP_RST_CODE      11'h001
`define ANNP_RESP_OKAY     2'h0
`define ANNP_RESP_SLVERR   2'h2

`endif

// >>> core/annp_pkg.sv
`include "annp_params.svh"

package annp_pkg;
    typedef struct packed {
        logic                     awready;
        logic                     wready;
        logic                     arready;
        logic                     aw_have;
        logic [`ANNP_ADDR_W-1:0]  aw_addr;
        logic                     w_have;
        logic [31:0]              w_data;
        logic [3:0]               w_strb;
        logic                     bvalid;
        logic [1:0]               bresp;
        logic                     rvalid;
        logic [31:0]              rdata;
        logic [1:0]               rresp;
        logic                     more;
        logic                     msg;
        logic                     ack;
        logic                     tog;
        logic [10:0]              code;
        logic [15:0]              tx_word;
    } annp_state_t;
endpackage

// >>> core/annp_tx_reg.sv
// The AXI4-Lite register port was decided locally.
`timescale 1ns/1ps
`include "annp_params.svh"

module annp_tx_reg #(
    parameter int ADDR_W = `ANNP_ADDR_W
) (
    input  wire logic              sys_clk,
    input  wire logic              rst_b,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic              page_exchanged,
    input  wire logic              exchanged_toggle,
    output logic [15:0]            next_page_word
);

    annp_pkg::annp_state_t s;
    annp_pkg::annp_state_t next_s;
    logic                  wr_fire;
    logic                  wr_hit;

    // ------------------------------------------------------------
    // address decode and read mux
    // ------------------------------------------------------------
    function automatic logic is_reg(input logic [ADDR_W-1:0] a,
                                    input logic [7:0] idx);
        return a[ADDR_W-1:2] == idx[ADDR_W-3:0];
    endfunction

    function automatic logic [31:0] read_mux(
        input logic [ADDR_W-1:0] a,
        input annp_pkg::annp_state_t st);
        logic [31:0] d;
        d = 32'h0000_0000;
        if (is_reg(a, `ANNP_IDX_TX)) begin
            d[`ANNP_BIT_MORE] = st.more;
            d[`ANNP_BIT_RESV] = 1'b0;                  // see (R02)
            d[`ANNP_BIT_MSG]  = st.msg;
            d[`ANNP_BIT_ACK]  = st.ack;
            d[`ANNP_BIT_TOG]  = st.tog;
            d[10:0]           = st.code;
        end else if (is_reg(a, `ANNP_IDX_CAP)) begin
            d[`ANNP_BIT_CAP] = 1'b1;                   // see (R09)
        end
        return d;
    endfunction

    function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
        return is_reg(a, `ANNP_IDX_TX) || is_reg(a, `ANNP_IDX_CAP);
    endfunction

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        next_s  = s;
        wr_fire = 1'b0;
        wr_hit  = 1'b0;
        if (s.awready && s_axi_awvalid) begin
            next_s.aw_have = 1'b1;
            next_s.aw_addr = s_axi_awaddr;
            next_s.awready = 1'b0;
        end
        if (s.wready && s_axi_wvalid) begin
            next_s.w_have = 1'b1;
            next_s.w_data = s_axi_wdata;
            next_s.w_strb = s_axi_wstrb;
            next_s.wready = 1'b0;
        end
        // commit once both halves are held
        if (s.aw_have && s.w_have && !s.bvalid) begin
            wr_fire        = 1'b1;
            wr_hit         = is_reg(s.aw_addr, `ANNP_IDX_TX);
            next_s.aw_have = 1'b0;
            next_s.w_have  = 1'b0;
            next_s.bvalid  = 1'b1;
            next_s.bresp   = is_mapped(s.aw_addr) ? `ANNP_RESP_OKAY
                                                  : `ANNP_RESP_SLVERR;
            if (wr_hit && s.w_strb[1]) begin
                next_s.more = s.w_data[`ANNP_BIT_MORE];  // see (R01)
                next_s.msg  = s.w_data[`ANNP_BIT_MSG];   // see (R03)
                next_s.ack  = s.w_data[`ANNP_BIT_ACK];   // see (R04)
                next_s.code[10:8] = s.w_data[10:8];      // see (R06)
            end
            if (wr_hit && s.w_strb[0]) begin
                next_s.code[7:0] = s.w_data[7:0];        // see (R06)
            end
        end
        if (s.bvalid && s_axi_bready) begin
            next_s.bvalid  = 1'b0;
            next_s.awready = 1'b1;
            next_s.wready  = 1'b1;
        end
        if (s.arready && s_axi_arvalid) begin
            next_s.rvalid  = 1'b1;
            next_s.arready = 1'b0;
            next_s.rdata   = read_mux(s_axi_araddr, s);
            next_s.rresp   = is_mapped(s_axi_araddr) ? `ANNP_RESP_OKAY
                                                     : `ANNP_RESP_SLVERR;
        end
        if (s.rvalid && s_axi_rready) begin
            next_s.rvalid  = 1'b0;
            next_s.arready = 1'b1;
        end
        if (page_exchanged) begin
            next_s.tog = ~exchanged_toggle;                // see (R05)
        end
        // message select travels with the code so the partner reads it
        next_s.tx_word = {next_s.more, 1'b0, next_s.msg,   // see (R07)
                          next_s.ack, next_s.tog,
                          next_s.code};                    // see (R08)
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            s         <= '0;
            s.awready <= 1'b1;
            s.wready  <= 1'b1;
            s.arready <= 1'b1;
            s.more    <= `ANNP_RST_MORE;
            s.msg     <= `ANNP_RST_MSG;
            s.ack     <= `ANNP_RST_ACK;
            s.tog     <= `ANNP_RST_TOG;
            s.code    <= `ANNP_RST_CODE;
            s.tx_word <= {`ANNP_RST_MORE, 1'b0, `ANNP_RST_MSG,
                          `ANNP_RST_ACK, `ANNP_RST_TOG, `ANNP_RST_CODE};
        end else begin
            s <= next_s;
        end
    end

    assign s_axi_awready  = s.awready;
    assign s_axi_wready   = s.wready;
    assign s_axi_bvalid   = s.bvalid;
    assign s_axi_bresp    = s.bresp;
    assign s_axi_arready  = s.arready;
    assign s_axi_rvalid   = s.rvalid;
    assign s_axi_rdata    = s.rdata;
    assign s_axi_rresp    = s.rresp;
    assign next_page_word = s.tx_word;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);

    property p_more_wr;
        wr_fire && wr_hit && s.w_strb[1] |=>
            s.more == $past(s.w_data[`ANNP_BIT_MORE]);
    endproperty
    a_more_wr: assert property (p_more_wr)                 // see (R01)
        else $error("more-pages flag not written");

    property p_resv_zero;
        s.rvalid |-> !s.rdata[`ANNP_BIT_RESV] && !next_page_word[14];
    endproperty
    a_resv_zero: assert property (p_resv_zero)             // see (R02)
        else $error("reserved bit not zero");

    property p_msg_wr;
        wr_fire && wr_hit && s.w_strb[1] |=>
            s.msg == $past(s.w_data[`ANNP_BIT_MSG]);
    endproperty
    a_msg_wr: assert property (p_msg_wr)                   // see (R03)
        else $error("message select not written");

    property p_ack_hold;
        !(wr_fire && wr_hit) |=> $stable(s.ack) && $stable(s.more);
    endproperty
    a_ack_hold: assert property (p_ack_hold)               // see (R04)
        else $error("comply acknowledge changed without write");

    property p_tog;
        page_exchanged |=> s.tog == !$past(exchanged_toggle) ##1
            ($past(page_exchanged) || $stable(s.tog));
    endproperty
    a_tog: assert property (p_tog)                         // see (R05)
        else $error("toggle not inverse of exchanged word");

    property p_code_lo;
        wr_fire && wr_hit && s.w_strb[0] |=>
            s.code[7:0] == $past(s.w_data[7:0]);
    endproperty
    a_code_lo: assert property (p_code_lo)                 // see (R06)
        else $error("code field not written");

    property p_word;
        ##1 next_page_word[`ANNP_BIT_MSG] == s.msg &&
            next_page_word == {s.more, 1'b0, s.msg, s.ack, s.tog, s.code};
    endproperty
    a_word: assert property (p_word)                       // see (R08)
        else $error("transmitted word differs from register");

    property p_cap;
        s.arready && s_axi_arvalid && is_reg(s_axi_araddr, `ANNP_IDX_CAP)
            |=> s.rvalid && s.rdata[`ANNP_BIT_CAP] ##1 1'b1;
    endproperty
    a_cap: assert property (p_cap)                         // see (R09)
        else $error("capability flag not read as one");

endmodule

// >>> verification/annp_link_model.sv
`timescale 1ns/1ps

module annp_link_model (
    input  wire logic        sys_clk,
    input  wire logic [15:0] next_page_word,
    output logic             page_exchanged,
    output logic             exchanged_toggle
);
    logic [15:0] sent;

    initial begin
        page_exchanged   = 1'b0;
        exchanged_toggle = 1'b0;
        sent             = 16'h0000;
    end

    // ----------------------------------------------------------------
    // one link code word exchange
    // ----------------------------------------------------------------
    // bit 13 of the captured word tells message from unformatted page
    task automatic exchange(input logic t);
        @(posedge sys_clk);
        page_exchanged   <= 1'b1;
        exchanged_toggle <= t;
        // take the word while it stands, before the pulse edge updates it
        @(negedge sys_clk);
        sent              = next_page_word;
        @(posedge sys_clk);
        page_exchanged   <= 1'b0;
        exchanged_toggle <= ~t;
    endtask
endmodule

// >>> verification/annp_tx_reg_tb.sv
`timescale 1ns/1ps
`include "annp_params.svh"

module annp_tx_reg_tb;
    localparam logic [7:0] A_TX  = 8'h1C;
    localparam logic [7:0] A_CAP = 8'h18;
    localparam logic [7:0] A_BAD = 8'h40;
    logic        sys_clk, rst_b, awv, awr, wv, wr_r, bv, br, arv, arr;
    logic        rv, rr, pex, ptog;
    logic [7:0]  awa, ara;
    logic [31:0] wd, rdat, rd;
    logic [3:0]  ws;
    logic [1:0]  bresp, rresp, rs;
    logic [15:0] word;
    int          mismatches, n_compared;

    annp_tx_reg annp_tx_reg_i (.sys_clk(sys_clk), .rst_b(rst_b),
        .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
        .s_axi_wready(wr_r), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
        .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rresp),
        .s_axi_rvalid(rv), .s_axi_rready(rr), .page_exchanged(pex),
        .exchanged_toggle(ptog), .next_page_word(word));
    annp_link_model annp_link_model_i (.sys_clk(sys_clk),
        .next_page_word(word), .page_exchanged(pex),
        .exchanged_toggle(ptog));

    always #4 sys_clk = ~sys_clk;

    // ----------------------------------------------------------------
    // checking and bus tasks
    // ----------------------------------------------------------------
    task automatic print_verdict();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            mismatches++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask

    task automatic hang(input int i);
        if (i == 50) begin
            mismatches++;
            $display("BAD bus answer exp done got timeout");
            print_verdict();
        end
    endtask

    task automatic wrr(input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] s, output logic [1:0] r);
        int i;
        awa <= a;
        wd  <= d;
        ws  <= s;
        awv <= 1'b1;
        wv  <= 1'b1;
        br  <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge sys_clk);
            if (awv && awr) awv <= 1'b0;
            if (wv && wr_r) wv <= 1'b0;
            if (bv) begin
                r = bresp;
                br <= 1'b0;
                break;
            end
        end
        hang(i);
        @(posedge sys_clk);
    endtask

    task automatic rdr(input logic [7:0] a, output logic [31:0] d,
                       output logic [1:0] r);
        int i;
        ara <= a;
        arv <= 1'b1;
        rr  <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge sys_clk);
            if (arv && arr) arv <= 1'b0;
            if (rv) begin
                d = rdat;
                r = rresp;
                rr <= 1'b0;
                break;
            end
        end
        hang(i);
        @(posedge sys_clk);
    endtask

    task automatic expect_tx(input logic [15:0] e);
        rdr(A_TX, rd, rs);
        chk("tx reg", {16'h0, e}, rd);
        chk("word", {16'h0, e}, {16'h0, word});
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        {sys_clk, rst_b, awv, wv, br, arv, rr} = '0;
        {awa, ara, wd, ws} = '0;
        mismatches = 0;
        n_compared = 0;
        repeat (4) @(posedge sys_clk);
        rst_b <= 1'b1;
        @(posedge sys_clk);
        expect_tx(16'h2001);
        chk("rresp", 32'h0, {30'h0, rs});
        wrr(A_TX, 32'hFFFF_FFFF, 4'hF, rs);
        chk("bresp", 32'h0, {30'h0, rs});
        expect_tx(16'hB7FF);
        wrr(A_TX, 32'h0000_0000, 4'h1, rs);
        expect_tx(16'hB700);
        annp_link_model_i.exchange(1'b0);
        chk("sent", 32'hB700, {16'h0, annp_link_model_i.sent});
        expect_tx(16'hBF00);
        annp_link_model_i.exchange(1'b1);
        expect_tx(16'hB700);
        wrr(A_TX, 32'h0000_4001, 4'h3, rs);
        expect_tx(16'h0001);
        rdr(A_CAP, rd, rs);
        chk("cap", 32'h4, rd);
        wrr(A_CAP, 32'h0, 4'hF, rs);
        chk("cap bresp", 32'h0, {30'h0, rs});
        rdr(A_CAP, rd, rs);
        chk("cap kept", 32'h4, rd);
        wrr(A_BAD, 32'hFFFF, 4'hF, rs);
        chk("bad bresp", 32'h2, {30'h0, rs});
        expect_tx(16'h0001);
        rdr(A_BAD, rd, rs);
        chk("bad rdata", 32'h0, rd);
        chk("bad rresp", 32'h2, {30'h0, rs});
        print_verdict();
    end
endmodule
